// File: converter_regs_pkg.sv
`default_nettype none
package converter_regs_pkg;

    // Bus target address, seven bits without the direction bit
    localparam logic [6:0] TARGET_ADDRESS = 7'h30;

    // Register offsets
    localparam logic [7:0] OUTPUT_SETPOINT_OFFSET = 8'h00;
    localparam logic [7:0] INDUCTOR_RESISTANCE_CFG_OFFSET = 8'h02;
    localparam logic [7:0] RAMP_CONFIG_OFFSET = 8'h03;
    localparam logic [7:0] OUTPUT_VOLTAGE_LOW_OFFSET = 8'h42;
    localparam logic [7:0] OUTPUT_VOLTAGE_HIGH_OFFSET = 8'h43;
    localparam logic [7:0] INPUT_VOLTAGE_READING_OFFSET = 8'h46;
    localparam logic [7:0] FAST_CURRENT_READING_OFFSET = 8'h48;

    // Field positions
    localparam int RESISTANCE_CODE_MSB = 7;
    localparam int RESISTANCE_CODE_LSB = 4;
    localparam int RAMP_SELECT_MSB = 2;
    localparam int RAMP_SELECT_LSB = 0;
    localparam int VOLTAGE_LOW_NIBBLE_LSB = 4;

    // Reset values
    localparam logic [7:0] OUTPUT_SETPOINT_RESET = 8'h46;
    localparam logic [3:0] RESISTANCE_CODE_RESET = 4'h0;
    localparam logic [2:0] RAMP_SELECT_RESET = 3'h4;
    localparam logic [11:0] OUTPUT_VOLTAGE_RESET = 12'h000;
    localparam logic [7:0] INPUT_VOLTAGE_RESET = 8'h00;
    localparam logic [7:0] FAST_CURRENT_RESET = 8'h00;

    // Timing
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int FAST_REFRESH_NS = 32000;
    localparam int FAST_REFRESH_CYCLES_INT = FAST_REFRESH_NS / CLOCK_PERIOD_NS;
    localparam logic [11:0] FAST_REFRESH_CYCLES =
        12'(FAST_REFRESH_CYCLES_INT);

    typedef enum logic [2:0] {
        link_idle,
        link_receive,
        link_ack,
        link_send,
        link_host_ack
    } link_state_type;

    typedef enum logic [1:0] {
        byte_address,
        byte_pointer,
        byte_data
    } byte_kind_type;

endpackage
`default_nettype wire

// File: converter_setpoint_telemetry_regs.sv
`timescale 1ns/10ps
`default_nettype none

module converter_setpoint_telemetry_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Two-wire bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Converter measurements
    input wire logic [11:0] output_voltage_sample,
    input wire logic output_voltage_sample_valid,
    input wire logic [7:0] input_voltage_sample,
    input wire logic input_voltage_sample_valid,
    input wire logic [7:0] fast_current_sample,
    // Converter controls
    output logic [7:0] output_setpoint,
    output logic [3:0] inductor_resistance_code,
    output logic [2:0] ramp_select
);

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        converter_regs_pkg::link_state_type state;
        converter_regs_pkg::byte_kind_type kind;
        logic [3:0] bit_count;
        logic [7:0] shift;
        logic [7:0] tx;
        logic [7:0] pointer;
        logic read_dir;
        logic sda_oe;
        logic sda_out;
        logic [7:0] setpoint;
        logic [3:0] resistance_code;
        logic [2:0] ramp_select;
        logic [11:0] output_voltage;
        logic low_read;
        logic high_read;
        logic [7:0] input_voltage;
        logic [7:0] fast_current;
        logic [11:0] fast_count;
    } state_type;

    state_type st_q;
    state_type st_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    function automatic logic [7:0] read_value(input logic [7:0] ptr,
                                              input state_type s);
        logic [7:0] value;
        value = 8'h00;
        if (ptr == converter_regs_pkg::OUTPUT_SETPOINT_OFFSET)
        begin
            value = s.setpoint;
        end
        else if (ptr == converter_regs_pkg::INDUCTOR_RESISTANCE_CFG_OFFSET)
        begin
            value[converter_regs_pkg::RESISTANCE_CODE_MSB:
                  converter_regs_pkg::RESISTANCE_CODE_LSB] =
                s.resistance_code;
        end
        else if (ptr == converter_regs_pkg::RAMP_CONFIG_OFFSET)
        begin
            value[converter_regs_pkg::RAMP_SELECT_MSB:
                  converter_regs_pkg::RAMP_SELECT_LSB] = s.ramp_select;
        end
        else if (ptr == converter_regs_pkg::OUTPUT_VOLTAGE_LOW_OFFSET)
        begin
            value[7:converter_regs_pkg::VOLTAGE_LOW_NIBBLE_LSB] =
                s.output_voltage[3:0];
        end
        else if (ptr == converter_regs_pkg::OUTPUT_VOLTAGE_HIGH_OFFSET)
        begin
            value = s.output_voltage[11:4];
        end
        else if (ptr == converter_regs_pkg::INPUT_VOLTAGE_READING_OFFSET)
        begin
            value = s.input_voltage;
        end
        else if (ptr == converter_regs_pkg::FAST_CURRENT_READING_OFFSET)
        begin
            value = s.fast_current;
        end
        return value;
    endfunction

    // Edges seen only on the second and third stages
    assign scl_rise = st_q.scl_s2 & ~st_q.scl_s3;
    assign scl_fall = ~st_q.scl_s2 & st_q.scl_s3;
    assign start_seen = st_q.scl_s2 & st_q.scl_s3 &
        ~st_q.sda_s2 & st_q.sda_s3;
    assign stop_seen = st_q.scl_s2 & st_q.scl_s3 &
        st_q.sda_s2 & ~st_q.sda_s3;

    always_comb
    begin
        st_d = st_q;
        st_d.scl_s1 = scl_in;
        st_d.scl_s2 = st_q.scl_s1;
        st_d.scl_s3 = st_q.scl_s2;
        st_d.sda_s1 = sda_in;
        st_d.sda_s2 = st_q.sda_s1;
        st_d.sda_s3 = st_q.sda_s2;
        st_d.sda_out = 1'b0;

        if (st_q.fast_count == converter_regs_pkg::FAST_REFRESH_CYCLES -
            12'h001)
        begin
            st_d.fast_count = 12'h000;
            st_d.fast_current = fast_current_sample;
        end
        else
        begin
            st_d.fast_count = st_q.fast_count + 12'h001;
        end

        if (input_voltage_sample_valid)
        begin
            st_d.input_voltage = input_voltage_sample;
        end

        // Read marks are only set on a clock fall, so a load never
        // lands in the cycle that marks a byte as read
        if (output_voltage_sample_valid && st_q.low_read &&
            st_q.high_read && !scl_fall)
        begin
            st_d.output_voltage = output_voltage_sample;
            st_d.low_read = 1'b0;
            st_d.high_read = 1'b0;
        end

        if (stop_seen)
        begin
            st_d.state = converter_regs_pkg::link_idle;
            st_d.sda_oe = 1'b0;
        end
        else if (start_seen)
        begin
            st_d.state = converter_regs_pkg::link_receive;
            st_d.kind = converter_regs_pkg::byte_address;
            st_d.bit_count = 4'h0;
            st_d.sda_oe = 1'b0;
        end
        else
        begin
            case (st_q.state)
                converter_regs_pkg::link_receive:
                begin
                    if (scl_rise)
                    begin
                        st_d.shift = {st_q.shift[6:0], st_q.sda_s2};
                        st_d.bit_count = st_q.bit_count + 4'h1;
                    end
                    else if (scl_fall && st_q.bit_count == 4'h8)
                    begin
                        st_d.bit_count = 4'h0;
                        st_d.sda_oe = 1'b1;
                        st_d.state = converter_regs_pkg::link_ack;
                        if (st_q.kind == converter_regs_pkg::byte_address)
                        begin
                            if (st_q.shift[7:1] !=
                                converter_regs_pkg::TARGET_ADDRESS)
                            begin
                                st_d.sda_oe = 1'b0;
                                st_d.state = converter_regs_pkg::link_idle;
                            end
                            st_d.read_dir = st_q.shift[0];
                        end
                    end
                end
                converter_regs_pkg::link_ack:
                begin
                    if (scl_fall)
                    begin
                        st_d.sda_oe = 1'b0;
                        st_d.state = converter_regs_pkg::link_receive;
                        if (st_q.kind == converter_regs_pkg::byte_address)
                        begin
                            if (st_q.read_dir)
                            begin
                                st_d.tx = read_value(st_q.pointer, st_q);
                                st_d.sda_oe = ~st_d.tx[7];
                                st_d.bit_count = 4'h1;
                                st_d.state = converter_regs_pkg::link_send;
                            end
                            else
                            begin
                                st_d.kind = converter_regs_pkg::byte_pointer;
                            end
                        end
                        else if (st_q.kind == converter_regs_pkg::byte_pointer)
                        begin
                            st_d.pointer = st_q.shift;
                            st_d.kind = converter_regs_pkg::byte_data;
                        end
                        else
                        begin
                            // Update on the fall that ends the acknowledge
                            if (st_q.pointer ==
                                converter_regs_pkg::OUTPUT_SETPOINT_OFFSET)
                            begin
                                st_d.setpoint = st_q.shift;
                            end
                            else if (st_q.pointer == converter_regs_pkg::
                                INDUCTOR_RESISTANCE_CFG_OFFSET)
                            begin
                                st_d.resistance_code = st_q.shift[
                                    converter_regs_pkg::RESISTANCE_CODE_MSB:
                                    converter_regs_pkg::RESISTANCE_CODE_LSB
                                ];
                            end
                            else if (st_q.pointer ==
                                converter_regs_pkg::RAMP_CONFIG_OFFSET)
                            begin
                                st_d.ramp_select = st_q.shift[
                                    converter_regs_pkg::RAMP_SELECT_MSB:
                                    converter_regs_pkg::RAMP_SELECT_LSB
                                ];
                            end
                            // Telemetry and unmapped offsets fall through
                            st_d.pointer = st_q.pointer + 8'h01;
                        end
                    end
                end
                converter_regs_pkg::link_send:
                begin
                    if (scl_fall)
                    begin
                        if (st_q.bit_count == 4'h8)
                        begin
                            st_d.sda_oe = 1'b0;
                            st_d.state = converter_regs_pkg::link_host_ack;
                            if (st_q.pointer ==
                                converter_regs_pkg::OUTPUT_VOLTAGE_LOW_OFFSET)
                            begin
                                st_d.low_read = 1'b1;
                            end
                            if (st_q.pointer ==
                                converter_regs_pkg::OUTPUT_VOLTAGE_HIGH_OFFSET)
                            begin
                                st_d.high_read = 1'b1;
                            end
                        end
                        else
                        begin
                            st_d.tx = {st_q.tx[6:0], 1'b0};
                            st_d.sda_oe = ~st_q.tx[6];
                            st_d.bit_count = st_q.bit_count + 4'h1;
                        end
                    end
                end
                converter_regs_pkg::link_host_ack:
                begin
                    if (scl_rise && st_q.sda_s2)
                    begin
                        // Host declined more data; wait for stop or start
                        st_d.state = converter_regs_pkg::link_idle;
                    end
                    else if (scl_fall)
                    begin
                        st_d.pointer = st_q.pointer + 8'h01;
                        st_d.tx = read_value(st_d.pointer, st_q);
                        st_d.sda_oe = ~st_d.tx[7];
                        st_d.bit_count = 4'h1;
                        st_d.state = converter_regs_pkg::link_send;
                    end
                end
                default:
                begin
                    st_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= '0;
            st_q.scl_s1 <= 1'b1;
            st_q.scl_s2 <= 1'b1;
            st_q.scl_s3 <= 1'b1;
            st_q.sda_s1 <= 1'b1;
            st_q.sda_s2 <= 1'b1;
            st_q.sda_s3 <= 1'b1;
            st_q.state <= converter_regs_pkg::link_idle;
            st_q.kind <= converter_regs_pkg::byte_address;
            st_q.setpoint <= converter_regs_pkg::OUTPUT_SETPOINT_RESET;
            st_q.resistance_code <= converter_regs_pkg::RESISTANCE_CODE_RESET;
            st_q.ramp_select <= converter_regs_pkg::RAMP_SELECT_RESET;
            st_q.output_voltage <= converter_regs_pkg::OUTPUT_VOLTAGE_RESET;
            st_q.input_voltage <= converter_regs_pkg::INPUT_VOLTAGE_RESET;
            st_q.fast_current <= converter_regs_pkg::FAST_CURRENT_RESET;
            // Both bytes count as read so the first sample loads
            st_q.low_read <= 1'b1;
            st_q.high_read <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign sda_out = st_q.sda_out;
    assign sda_oe = st_q.sda_oe;
    assign output_setpoint = st_q.setpoint;
    assign inductor_resistance_code = st_q.resistance_code;
    assign ramp_select = st_q.ramp_select;

endmodule
`default_nettype wire

// File: converter_regs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module converter_regs_properties (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Converter controls
    input wire logic [7:0] output_setpoint,
    input wire logic [3:0] inductor_resistance_code,
    input wire logic [2:0] ramp_select
);
    logic first_q;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Marks the first edge after reset release
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    AST_SDA_OUT_LOW:
        assert property (sda_out == 1'b0)
        else $error("data pin drive value not low");
    AST_RESET_STATE:
        assert property (first_q |-> output_setpoint == 8'h46 &&
            inductor_resistance_code == 4'h0 && ramp_select == 3'h4 && !sda_oe)
        else $error("controls not at power-on values");
    AST_SETPOINT_ON_FALL:
        assert property (!$stable(output_setpoint) |->
            !scl_in && $past(scl_in, 7))
        else $error("setpoint changed away from a clock fall");
    AST_SETPOINT_AFTER_ACK:
        assert property (!$stable(output_setpoint) |-> $past(sda_oe, 8))
        else $error("setpoint changed without an acknowledge");
    AST_CODE_ON_FALL:
        assert property (!$stable(inductor_resistance_code) |->
            !scl_in && $past(scl_in, 7))
        else $error("resistance code changed away from a clock fall");
    AST_RAMP_ON_FALL:
        assert property (!$stable(ramp_select) |->
            !scl_in && $past(scl_in, 7))
        else $error("ramp selector changed away from a clock fall");
    AST_OE_ON_FALL:
        assert property ($changed(sda_oe) |-> !scl_in && $past(scl_in, 7))
        else $error("data pin drive changed away from a clock fall");
    AST_OE_STANDS:
        assert property ($rose(sda_oe) |=> sda_oe [*7])
        else $error("data pin drive dropped within a bit");
endmodule
`default_nettype wire

// File: bus_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module bus_host_model (
    // Clock
    input wire logic ref_clk,
    // Bus pins
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic sda_low = 1'b0;

    // Pulled-up wire, low while either party pulls it
    assign sda = !(sda_low || sda_oe);
    initial scl = 1'b1;

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Phases well above eight cycles; data moves after clock fall
    task automatic bit_io(input logic b, output logic s);
        sda_low <= !b;
        tick(8);
        scl <= 1'b1;
        tick(5);
        @(negedge ref_clk) s = sda;
        tick(5);
        scl <= 1'b0;
        tick(3);
    endtask

    task automatic start();
        sda_low <= 1'b0;
        tick(8);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b1;
        tick(10);
        scl <= 1'b0;
        tick(3);
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        tick(8);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b0;
        tick(10);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask

    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            b[i] = s;
        end
        bit_io(nack, s);
    endtask

    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d,
        output logic ok);
        logic a0;
        logic a1;
        logic a2;
        start();
        send_byte({converter_regs_pkg::TARGET_ADDRESS, 1'b0}, a0);
        send_byte(ptr, a1);
        send_byte(d, a2);
        stop();
        ok = a0 && a1 && a2;
    endtask

    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
        logic a;
        start();
        send_byte({converter_regs_pkg::TARGET_ADDRESS, 1'b0}, a);
        send_byte(ptr, a);
        start();
        send_byte({converter_regs_pkg::TARGET_ADDRESS, 1'b1}, a);
        recv_byte(1'b1, d);
        stop();
    endtask
endmodule
`default_nettype wire

// File: tb_converter_setpoint_telemetry_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_converter_setpoint_telemetry_regs;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic scl;
    logic sda;
    logic sda_out;
    logic sda_oe;
    logic [11:0] vout_sample = 12'h000;
    logic vout_valid = 1'b0;
    logic [7:0] vin_sample = 8'h00;
    logic vin_valid = 1'b0;
    logic [7:0] fast_sample = 8'h00;
    logic [7:0] output_setpoint;
    logic [3:0] inductor_resistance_code;
    logic [2:0] ramp_select;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #4 ref_clk = !ref_clk;

    // Edges since reset release, to place stimulus against the refresh
    always @(posedge ref_clk)
    begin
        if (!reset_n)
            cycles <= 0;
        else
            cycles <= cycles + 1;
    end

    converter_setpoint_telemetry_regs dut (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .scl_in(scl),
        .sda_in(sda),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .output_voltage_sample(vout_sample),
        .output_voltage_sample_valid(vout_valid),
        .input_voltage_sample(vin_sample),
        .input_voltage_sample_valid(vin_valid),
        .fast_current_sample(fast_sample),
        .output_setpoint(output_setpoint),
        .inductor_resistance_code(inductor_resistance_code),
        .ramp_select(ramp_select)
    );

    bus_host_model host (
        .ref_clk(ref_clk),
        .sda_oe(sda_oe),
        .scl(scl),
        .sda(sda)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] ptr, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(ptr, d);
        check(d, exp);
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        logic ok;
        host.write_reg(ptr, d, ok);
        check(8'(ok), 8'h01);
    endtask

    task automatic pulse_vout(input logic [11:0] v);
        @(posedge ref_clk) vout_sample <= v;
        vout_valid <= 1'b1;
        @(posedge ref_clk) vout_valid <= 1'b0;
    endtask

    task automatic test_reset();
        check(output_setpoint, 8'h46);
        check(8'(inductor_resistance_code), 8'h00);
        check(8'(ramp_select), 8'h04);
        rd_check(8'h00, 8'h46);
        rd_check(8'h02, 8'h00);
        rd_check(8'h03, 8'h04);
        rd_check(8'h46, 8'h00);
        $display("test_reset done");
    endtask

    task automatic test_config();
        wr(8'h00, 8'h79);
        check(output_setpoint, 8'h79);
        rd_check(8'h00, 8'h79);
        wr(8'h02, 8'hF0);
        check(8'(inductor_resistance_code), 8'h0F);
        rd_check(8'h02, 8'hF0);
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h03, 8'(i));
            check(8'(ramp_select), 8'(i));
        end
        rd_check(8'h03, 8'h07);
        $display("test_config done");
    endtask

    task automatic test_wrong_address();
        logic a;
        host.start();
        host.send_byte(8'h62, a);
        check(8'(a), 8'h00);
        host.send_byte(8'h00, a);
        host.send_byte(8'h11, a);
        host.stop();
        check(output_setpoint, 8'h79);
        $display("test_wrong_address done");
    endtask

    // Host reads both bytes to release the frozen result
    task automatic test_voltage();
        pulse_vout(12'hABC);
        rd_check(8'h42, 8'hC0);
        rd_check(8'h43, 8'hAB);
        pulse_vout(12'h123);
        rd_check(8'h42, 8'h30);
        pulse_vout(12'h456);
        rd_check(8'h43, 8'h12);
        pulse_vout(12'h789);
        rd_check(8'h42, 8'h90);
        rd_check(8'h43, 8'h78);
        $display("test_voltage done");
    endtask

    task automatic test_read_only();
        @(posedge ref_clk) vin_sample <= 8'h9A;
        vin_valid <= 1'b1;
        @(posedge ref_clk) vin_valid <= 1'b0;
        rd_check(8'h46, 8'h9A);
        wr(8'h46, 8'h00);
        wr(8'h43, 8'hFF);
        rd_check(8'h46, 8'h9A);
        rd_check(8'h43, 8'h78);
        rd_check(8'h01, 8'h00);
        $display("test_read_only done");
    endtask

    // Host keeps the bus for several bytes; pointer steps each byte
    task automatic test_burst();
        logic [3:0] a;
        logic [7:0] d;
        host.start();
        host.send_byte(8'h60, a[0]);
        host.send_byte(8'h02, a[1]);
        host.send_byte(8'hA0, a[2]);
        host.send_byte(8'h03, a[3]);
        host.stop();
        check(8'(a), 8'h0F);
        check(8'(inductor_resistance_code), 8'h0A);
        check(8'(ramp_select), 8'h03);
        pulse_vout(12'h5D2);
        host.start();
        host.send_byte(8'h60, a[0]);
        host.send_byte(8'h42, a[1]);
        host.start();
        host.send_byte(8'h61, a[2]);
        host.recv_byte(1'b0, d);
        check(d, 8'h20);
        host.recv_byte(1'b1, d);
        check(d, 8'h5D);
        host.stop();
        check(8'(a[2:0]), 8'h07);
        $display("test_burst done");
    endtask

    // Second reset on an idle bus brings every control back
    task automatic test_mid_reset();
        @(posedge ref_clk) reset_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check(output_setpoint, 8'h46);
        check(8'(inductor_resistance_code), 8'h00);
        check(8'(ramp_select), 8'h04);
        rd_check(8'h42, 8'h00);
        $display("test_mid_reset done");
    endtask

    // New sample must wait for the next refresh, not show at once
    task automatic test_fast_current();
        @(posedge ref_clk) fast_sample <= 8'h21;
        repeat (4000) @(posedge ref_clk);
        rd_check(8'h48, 8'h21);
        while (cycles % converter_regs_pkg::FAST_REFRESH_CYCLES_INT != 100)
            @(posedge ref_clk);
        fast_sample <= 8'h5E;
        rd_check(8'h48, 8'h21);
        repeat (4000) @(posedge ref_clk);
        rd_check(8'h48, 8'h5E);
        $display("test_fast_current done");
    endtask

    task automatic final_report();
        $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        test_reset();
        test_config();
        test_wrong_address();
        test_voltage();
        test_read_only();
        test_burst();
        test_mid_reset();
        test_fast_current();
        final_report();
    end

    // Whole run needs about 38000 cycles
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        mismatches++;
        final_report();
    end
endmodule

bind converter_setpoint_telemetry_regs converter_regs_properties props (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .output_setpoint(output_setpoint),
    .inductor_resistance_code(inductor_resistance_code),
    .ramp_select(ramp_select)
);
`default_nettype wire
